// [src/prs_pkg.sv]
// Function
// - Each rail sense compared to fixed threshold gives a per-rail compliance flag
// - Separate inputs: up-request rising edge starts power-up only from idle
// - Separate inputs: down-request falling edge starts power-down only when all on
// - Combined input: rise starts up from idle, fall starts down from all-on
// - Internal fault pulls shared fault line low and enters fault-entry state
// - Fault line is open drain; device only pulls low or releases it
// - Fault line held low externally forces fault-entry from any state but the two fault states
// - Power-up: after request, wait first delay, then raise enable 1
// - Power-down: after enable 1 drops, wait first delay, then drop complete
// - Power-up: rail 1 good, wait second delay, raise enable 2
// - Power-down: after enable 2 drops, wait second delay, drop enable 1
// - Power-up: rail 2 good, wait third delay, raise enable 3
// - Power-down: after enable 3 drops, wait third delay, drop enable 2
// - Rail 3 good, wait fourth delay, raise enable 4; enable 4 drops first
// - Rail must comply within blanking time after its enable, else fault
// - Complete output high after power-up, held until first delay, low on fault
// - All-rails-good output is AND of four compliance flags
package prs_pkg;
  localparam int PRS_RAILS = 4;
  localparam int PRS_CNT_W = 16;
  // Combined-input variant select value
  localparam logic PRS_COMBINED = 1'b1;
  localparam logic [PRS_CNT_W-1:0] PRS_DLY_RST = 16'h0000;
  localparam logic [2:0] PRS_STAGE_RST = 3'h0;
  // Fault line must read low this long, in ns, to count as external fault
  localparam int PRS_FLT_FILT_NS = 120;
  localparam int PRS_CLK_NS = 40;
  localparam int PRS_FLT_FILT_CYC = (PRS_FLT_FILT_NS + PRS_CLK_NS - 1)
    / PRS_CLK_NS;
  // Hold in the fault wait state before the device may restart
  localparam int PRS_FHOLD_NS = 35000;
  localparam int PRS_FHOLD_CYC = (PRS_FHOLD_NS + PRS_CLK_NS - 1) / PRS_CLK_NS;
  typedef enum logic [2:0] {
    PRS_IDLE = 3'b000,
    PRS_UP_DLY = 3'b001,
    PRS_UP_BLANK = 3'b011,
    PRS_ALL_ON = 3'b010,
    PRS_DN_DLY = 3'b110,
    PRS_FAULT = 3'b111,
    PRS_FWAIT = 3'b101
  } prs_state_type;
endpackage

// [src/prs_stage_timer.sv]
`timescale 1ns/10ps
// Loadable down-counter; done pulses when the load value is used up
module prs_stage_timer #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] value,
  input wire logic run,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } prs_tmr_type;
  prs_tmr_type s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (load) begin
      s_nxt.cnt = value;
    // One pulse only; a held done would skip the next stage
    end else if (run && !s_r.done) begin
      if (s_r.cnt == '0) begin
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign done = s_r.done;
endmodule // prs_stage_timer

// [src/prs_seq.sv]
`timescale 1ns/10ps
module prs_seq #(
  parameter int FHOLD_CYC = prs_pkg::PRS_FHOLD_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic combined_mode,
  input wire logic up_request,
  input wire logic down_request,
  input wire logic updown_request,
  input wire logic [prs_pkg::PRS_RAILS-1:0] rail_sense_input,
  input wire logic [prs_pkg::PRS_CNT_W-1:0] stage1_delay_setting,
  input wire logic [prs_pkg::PRS_CNT_W-1:0] stage2_delay_setting,
  input wire logic [prs_pkg::PRS_CNT_W-1:0] stage3_delay_setting,
  input wire logic [prs_pkg::PRS_CNT_W-1:0] stage4_delay_setting,
  input wire logic [prs_pkg::PRS_CNT_W-1:0] blanking_time_setting,
  input wire logic fault_in,
  output logic fault_out,
  output logic fault_oe,
  output logic [prs_pkg::PRS_RAILS-1:0] regulator_enable,
  output logic sequence_complete,
  output logic all_rails_good,
  output logic fault_active
);
  import prs_pkg::*;
  typedef struct packed {
    prs_state_type st;
    logic [2:0] stage;
    logic [PRS_RAILS-1:0] en;
    logic done;
    logic pg;
    logic pull;
    logic up_d;
    logic dn_d;
    logic ud_d;
    logic [3:0] flt_cnt;
    logic [15:0] hold;
    logic load;
    logic act;
  } prs_seq_type;
  prs_seq_type s_r, s_nxt;
  logic tmr_done;
  logic [PRS_CNT_W-1:0] tmr_val;
  logic up_edge;
  logic dn_edge;
  logic ext_fault;
  logic [PRS_RAILS-1:0] comply;
  logic tmr_run;

  // Comparator result arrives as a digital level per rail
  assign comply = rail_sense_input;
  assign up_edge = combined_mode ? (updown_request && !s_r.ud_d)
    : (up_request && !s_r.up_d);
  assign dn_edge = combined_mode ? (!updown_request && s_r.ud_d)
    : (!down_request && s_r.dn_d);
  // Own pull excluded: only a foreign low counts as external
  assign ext_fault = (s_r.flt_cnt >= 4'(PRS_FLT_FILT_CYC));

  always_comb begin
    case (s_r.stage)
      3'h0: tmr_val = stage1_delay_setting;
      3'h1: tmr_val = stage2_delay_setting;
      3'h2: tmr_val = stage3_delay_setting;
      3'h3: tmr_val = stage4_delay_setting;
      default: tmr_val = blanking_time_setting;
    endcase
  end
  assign tmr_run = (s_r.st == PRS_UP_DLY) || (s_r.st == PRS_DN_DLY)
    || (s_r.st == PRS_UP_BLANK);

  prs_stage_timer #(.W(PRS_CNT_W)) u_tmr (
    .mclk(mclk),
    .rstn(rstn),
    .load(s_r.load),
    .value(tmr_val),
    .run(tmr_run),
    .done(tmr_done)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.load = 1'b0;
    s_nxt.up_d = up_request;
    s_nxt.dn_d = down_request;
    s_nxt.ud_d = updown_request;
    s_nxt.pg = &comply;
    if (!fault_in && !s_r.pull) begin
      if (s_r.flt_cnt != 4'hf) begin
        s_nxt.flt_cnt = s_r.flt_cnt + 4'h1;
      end
    end else begin
      s_nxt.flt_cnt = 4'h0;
    end
    case (s_r.st)
      PRS_IDLE: begin
        if (up_edge) begin
          s_nxt.st = PRS_UP_DLY;
          s_nxt.stage = 3'h0;
          s_nxt.load = 1'b1;
        end
      end
      PRS_UP_DLY: begin
        if (tmr_done) begin
          s_nxt.en[s_r.stage[1:0]] = 1'b1;
          s_nxt.st = PRS_UP_BLANK;
          s_nxt.stage = 3'h4;
          s_nxt.load = 1'b1;
        end
      end
      PRS_UP_BLANK: begin
        // Rail of the highest enable so far must come good
        if (comply[s_nxt.en[3] ? 3 : s_nxt.en[2] ? 2 : s_nxt.en[1] ? 1
            : 0]) begin
          if (s_r.en[3]) begin
            s_nxt.st = PRS_ALL_ON;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st = PRS_UP_DLY;
            s_nxt.stage = s_r.en[2] ? 3'h3 : s_r.en[1] ? 3'h2 : 3'h1;
            s_nxt.load = 1'b1;
          end
        end else if (tmr_done) begin
          s_nxt.st = PRS_FAULT;
        end
      end
      PRS_ALL_ON: begin
        if (dn_edge) begin
          s_nxt.en[3] = 1'b0;
          s_nxt.st = PRS_DN_DLY;
          s_nxt.stage = 3'h3;
          s_nxt.load = 1'b1;
        end else if (!(&comply)) begin
          s_nxt.st = PRS_FAULT;
        end
      end
      PRS_DN_DLY: begin
        if (tmr_done) begin
          if (s_r.stage == 3'h0) begin
            s_nxt.done = 1'b0;
            s_nxt.st = PRS_IDLE;
          end else begin
            // Stage n delay then drop enable n-1
            s_nxt.en[s_r.stage[1:0] - 2'h1] = 1'b0;
            s_nxt.stage = s_r.stage - 3'h1;
            s_nxt.load = 1'b1;
          end
        end
      end
      PRS_FAULT: begin
        s_nxt.en = '0;
        s_nxt.done = 1'b0;
        s_nxt.pull = 1'b1;
        s_nxt.hold = 16'h0;
        s_nxt.st = PRS_FWAIT;
      end
      PRS_FWAIT: begin
        // Up request (updown in combined mode) must be low before restarting, avoiding instant rerun
        if (s_r.hold != 16'hffff) begin
          s_nxt.hold = s_r.hold + 16'h1;
        end
        if (s_r.hold >= 16'(FHOLD_CYC)) begin
          s_nxt.pull = 1'b0;
          if ((combined_mode ? !updown_request : !up_request)
              && fault_in && !ext_fault) begin
            s_nxt.st = PRS_IDLE;
          end
        end
      end
      default: s_nxt.st = PRS_FAULT;
    endcase
    if (ext_fault && s_r.st != PRS_FAULT && s_r.st != PRS_FWAIT) begin
      s_nxt.st = PRS_FAULT;
      s_nxt.en = '0;
      s_nxt.done = 1'b0;
    end
    // Registered so the output comes straight from a flop
    s_nxt.act = (s_nxt.st == PRS_FAULT) || (s_nxt.st == PRS_FWAIT);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_r <= '{st: PRS_IDLE, stage: PRS_STAGE_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Only ever drives low or releases
  assign fault_out = 1'b0;
  assign fault_oe = s_r.pull;
  assign regulator_enable = s_r.en;
  assign sequence_complete = s_r.done;
  assign all_rails_good = s_r.pg;
  assign fault_active = s_r.act;

  a_up_from_idle: assert property (@(posedge mclk) disable iff (!rstn)
    (s_r.st != PRS_IDLE && $past(s_r.st) == PRS_IDLE && !$past(ext_fault))
    |-> $past(up_edge)) else $error("start outside idle");
  a_down_from_on: assert property (@(posedge mclk) disable iff (!rstn)
    (s_r.st == PRS_DN_DLY && $past(s_r.st) == PRS_ALL_ON)
    |-> $past(dn_edge)) else $error("down not from all-on");
  a_fault_pull: assert property (@(posedge mclk) disable iff (!rstn)
    s_r.st == PRS_FAULT |=> fault_oe && regulator_enable == 4'h0)
    else $error("fault not pulled");
  a_pull_only: assert property (@(posedge mclk) disable iff (!rstn)
    fault_oe |-> fault_active && fault_out == 1'b0)
    else $error("fault line driven high");
  a_ext_fault: assert property (@(posedge mclk) disable iff (!rstn)
    ext_fault |=> fault_active) else $error("ext fault missed");
  a_en_order: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(regulator_enable[1]) |-> regulator_enable[0])
    else $error("enable order");
  a_done_drop: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(sequence_complete) && !fault_active |-> regulator_enable == 4'h0)
    else $error("complete dropped early");
  a_pg_and: assert property (@(posedge mclk) disable iff (!rstn)
    all_rails_good == $past(&comply)) else $error("power good wrong");
  a_dn_first: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(regulator_enable[2]) && !fault_active |-> !regulator_enable[3])
    else $error("enable 4 not first");
  c_power_up: cover property (@(posedge mclk) $rose(sequence_complete));
  c_power_down: cover property (@(posedge mclk)
    $fell(sequence_complete) && !fault_active);
  c_blank_fault: cover property (@(posedge mclk)
    s_r.st == PRS_UP_BLANK ##1 s_r.st == PRS_FAULT);
  c_ext_fault: cover property (@(posedge mclk) ext_fault);
endmodule // prs_seq

// [sim/prs_rail_model.sv]
`timescale 1ns/10ps
// Regulators with their sensed rails, plus a peer on the fault wire
module prs_rail_model (
  input wire logic mclk,
  input wire logic [3:0] en,
  input wire logic [7:0] lag,
  input wire logic fault_oe,
  input wire logic peer_pull,
  output logic [3:0] rail,
  output logic fault_line
);
  logic [7:0] cnt [4];
  // Pull-up wire; nobody ever drives it high
  assign fault_line = !(fault_oe || peer_pull);
  initial rail = 4'h0;
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= en[i] ? cnt[i] + 8'h01 : 8'h00;
      // Rail collapses at once when its regulator turns off
      rail[i] <= en[i] && (rail[i] || cnt[i] >= lag);
    end
  end
endmodule // prs_rail_model

// [sim/power_rail_sequencer_tb.sv]
`timescale 1ns/10ps
module power_rail_sequencer_tb;
  import prs_pkg::*;
  localparam int L = 5;
  localparam int BL = 40;
  localparam int D [4] = '{10, 12, 14, 16};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic comb_r = 1'b0;
  logic up_r = 1'b0;
  logic dn_r = 1'b1;
  logic ud_r = 1'b0;
  logic peer = 1'b0;
  logic [7:0] lag = 8'h05;
  logic [3:0] rail, en;
  logic fault_line, fault_oe, done, good, factive;
  logic [6:0] obs;
  int fail_count = 0;
  int n_checks = 0;
  assign obs = {factive, fault_oe, done, en};
  initial forever #20 mclk = ~mclk;
  prs_rail_model part (.mclk(mclk), .en(en), .lag(lag),
    .fault_oe(fault_oe), .peer_pull(peer), .rail(rail),
    .fault_line(fault_line));
  prs_seq #(.FHOLD_CYC(8)) dut (.mclk(mclk), .rstn(rstn),
    .combined_mode(comb_r), .up_request(up_r), .down_request(dn_r),
    .updown_request(ud_r), .rail_sense_input(rail),
    .stage1_delay_setting(16'(D[0])), .stage2_delay_setting(16'(D[1])),
    .stage3_delay_setting(16'(D[2])), .stage4_delay_setting(16'(D[3])),
    .blanking_time_setting(16'(BL)), .fault_in(fault_line),
    .fault_out(), .fault_oe(fault_oe), .regulator_enable(en),
    .sequence_complete(done), .all_rails_good(good),
    .fault_active(factive));
  task automatic report_and_stop;
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cyc(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("ERROR %0t cycles %h range %h %h", $time, n, lo, hi);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_bit(input int b, input logic v, output int n);
    n = 0;
    while (obs[b] !== v) begin
      step(1);
      n++;
      if (n > 300) begin
        fail_count++;
        report_and_stop();
      end
    end
  endtask
  task automatic power_up(input logic cm);
    int n;
    comb_r = cm;
    up_r = !cm;
    ud_r = cm;
    for (int k = 0; k < 4; k++) begin
      wait_bit(k, 1'b1, n);
      chk_cyc(n, (k > 0) ? L + D[k] : D[k], D[k] + L + 6);
      chk(obs, 7'((1 << (k + 1)) - 1));
    end
    wait_bit(4, 1'b1, n);
    chk_cyc(n, 0, L + 4);
    step(2);
    chk(7'(good), 7'h01);
    if (!cm) begin
      up_r = 1'b0;
      step(1);
      up_r = 1'b1;
      step(20);
      chk(obs, 7'h1f);
    end
  endtask
  task automatic power_down(input logic cm);
    int n;
    if (cm)
      ud_r = 1'b0;
    else
      dn_r = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      wait_bit(k, 1'b0, n);
      chk_cyc(n, (k < 3) ? D[k + 1] : 0, (k < 3) ? D[k + 1] + 4 : 4);
      chk(obs, {3'h1, 4'((1 << k) - 1)});
    end
    wait_bit(4, 1'b0, n);
    chk_cyc(n, D[0], D[0] + 4);
    dn_r = 1'b1;
    up_r = 1'b0;
    step(4);
    chk(obs, 7'h00);
  endtask
  task automatic blank_fault;
    int n;
    comb_r = 1'b0;
    lag = 8'h3c;
    up_r = 1'b1;
    wait_bit(5, 1'b1, n);
    chk_cyc(n, D[0] + BL, D[0] + BL + 8);
    step(1);
    chk(obs, 7'h60);
    up_r = 1'b0;
    lag = 8'h05;
    wait_bit(5, 1'b0, n);
    chk_cyc(n, 6, 12);
    step(4);
    chk(obs, 7'h00);
  endtask
  task automatic ext_fault;
    int n;
    power_up(1'b0);
    peer = 1'b1;
    wait_bit(0, 1'b0, n);
    chk_cyc(n, 2, 8);
    step(1);
    chk(obs, 7'h60);
    step(1);
    chk(7'(good), 7'h00);
    peer = 1'b0;
    up_r = 1'b0;
    wait_bit(6, 1'b0, n);
    chk(obs, 7'h00);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rstn = 1'b1;
    step(2);
    dn_r = 1'b0;
    step(20);
    chk(obs, 7'h00);
    dn_r = 1'b1;
    power_up(1'b0);
    power_down(1'b0);
    power_up(1'b1);
    power_down(1'b1);
    blank_fault();
    ext_fault();
    report_and_stop();
  end
endmodule // power_rail_sequencer_tb
